// ===== pkg/imss_consts.svh
// Purpose: offsets, reset values and timing counts of the service sequencer
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   definitions only
`ifndef IMSS_CONSTS_SVH
`define IMSS_CONSTS_SVH
`define OFF_CTRL      12'h000
`define OFF_COUNT     12'h004
`define OFF_CHAN      12'h008
`define OFF_TPTR      12'h00C
`define OFF_DPTR      12'h010
`define OFF_RING      12'h014
`define OFF_CMP       12'h018
`define OFF_PAT       12'h01C
`define OFF_STAT      12'h020
`define OFF_ACKCFG    12'h024
`define OFF_RAM       12'h400
`define CTRL_RST      9'h100
`define ZERO16        16'h0000
`define ONE16         16'h0001
`define PRIO_CLKS     4'h8
`define DEFER_CLKS    4'h8
`define ACK_VEC_CLKS  12'h01A
`define ACK_CS_CLKS   12'h016
`define ODD_SP_CLKS   12'h004
`define PERIPHERAL_RAM_STK_CLKS 12'h003
`define SLOW_STK_CLKS 12'h00B
`endif

// ===== pkg/imss_pkg.sv
// Purpose: types shared by the service sequencer and its bench
// Assumes: nothing
// Notes:   struct fields fix the register bit layout, msb first
package imss_pkg;
    typedef enum logic [1:0] {MODE_OFF, MODE_PATTERN, MODE_COUNTER} mode_e;
    typedef enum {S_IDLE, S_TIMER, S_DATA, S_COUNT, S_ACK} state_e;
    typedef struct packed {
        logic  irq_mask;
        logic  retain_tptr;
        logic  step_up;
        logic  vector_on_complete_enable;
        logic  service_mode_bit;
        logic  ring;
        logic  auto_add;
        mode_e mode;
    } ctrl_s;
    typedef struct packed {
        logic [7:0] stack_wait;
        logic [7:0] branch_wait;
        logic [7:0] vec_wait;
        logic       stack_slow;
        logic       stack_peripheral_ram;
        logic       sp_odd;
        logic       ctx_switch;
    } ack_cfg_s;
    typedef struct packed {
        logic insn_done;
        logic insn_defers;
        logic insn_suspendable;
        logic sw_irq;
    } cpu_in_s;
endpackage : imss_pkg

// ===== hw/interrupt_macro_service_sequencer.sv
// Purpose: interrupt acknowledge and pattern/timer/counter transfer sequencer
// Assumes: one clock pclk, APB register access, channel memory inside
// Notes:   channel memory is 256 x 16 bits, indexed by low pointer bits
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "imss_consts.svh"
module interrupt_macro_service_sequencer (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // request pin and cpu sequencer
    input  wire logic              external_edge_request,
    input  wire imss_pkg::cpu_in_s cpu,
    // cpu control
    output logic                   suspend_req,
    output logic                   resume_pulse,
    output logic                   handler_start,
    output logic                   handler_ctx,
    output logic                   channel_busy,
    // peripheral targets
    output logic      [15:0]       compare_match_reg,
    output logic      [7:0]        pattern_output_buffer
);
    import imss_pkg::*;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    state_e      state;
    ctrl_s       ctrl;
    ack_cfg_s    ack_cfg;
    logic [15:0] ram [0:255];
    logic [15:0] transfer_count;
    logic [7:0]  chan_ptr;
    logic [23:0] timer_data_pointer;
    logic [23:0] pattern_data_pointer;
    logic [7:0]  ring_length;
    logic [7:0]  ring_step_counter;
    logic        req_s1, req_s2, req_s3;
    logic        req_flag;
    logic [3:0]  prio_cnt;
    logic [3:0]  defer_cnt;
    logic        sw_pend;
    logic        suspended;
    logic [11:0] ack_cnt;

    // apb decode
    wire         apb_acc  = psel & penable & ~pready;
    wire         apb_wr   = apb_acc & pwrite;
    wire         ram_sel  = (paddr[11:10] == 2'(`OFF_RAM >> 10));
    wire [7:0]   ram_idx  = paddr[9:2];
    wire         mapped   = ram_sel | hit(paddr, `OFF_CTRL) | hit(paddr, `OFF_COUNT)
                          | hit(paddr, `OFF_CHAN) | hit(paddr, `OFF_TPTR)
                          | hit(paddr, `OFF_DPTR) | hit(paddr, `OFF_RING)
                          | hit(paddr, `OFF_CMP) | hit(paddr, `OFF_PAT)
                          | hit(paddr, `OFF_STAT) | hit(paddr, `OFF_ACKCFG);
    wire         wr_ctrl  = apb_wr & hit(paddr, `OFF_CTRL);
    wire         wr_count = apb_wr & hit(paddr, `OFF_COUNT);
    wire         wr_tptr  = apb_wr & hit(paddr, `OFF_TPTR);
    wire         wr_dptr  = apb_wr & hit(paddr, `OFF_DPTR);
    wire         wr_ring  = apb_wr & hit(paddr, `OFF_RING);
    wire         wr_cmp   = apb_wr & hit(paddr, `OFF_CMP);
    wire [31:0]  stat_val = {26'h0, suspended, sw_pend, (defer_cnt != 4'h0),
                             (prio_cnt != 4'h0), (state != S_IDLE), req_flag};
    wire [31:0]  rd_val   =
        ram_sel                   ? {16'h0, ram[ram_idx]} :
        hit(paddr, `OFF_CTRL)     ? {23'h0, ctrl} :
        hit(paddr, `OFF_COUNT)    ? {16'h0, transfer_count} :
        hit(paddr, `OFF_CHAN)     ? {24'h0, chan_ptr} :
        hit(paddr, `OFF_TPTR)     ? {8'h0, timer_data_pointer} :
        hit(paddr, `OFF_DPTR)     ? {8'h0, pattern_data_pointer} :
        hit(paddr, `OFF_RING)     ? {16'h0, ring_step_counter, ring_length} :
        hit(paddr, `OFF_CMP)      ? {16'h0, compare_match_reg} :
        hit(paddr, `OFF_PAT)      ? {24'h0, pattern_output_buffer} :
        hit(paddr, `OFF_STAT)     ? stat_val :
        hit(paddr, `OFF_ACKCFG)   ? {4'h0, ack_cfg} : 32'h0;

    // request acceptance
    wire         req_edge   = req_s2 & ~req_s3;
    wire         next_flag;
    wire         flag_clr;
    wire         req_ready  = req_flag & (prio_cnt == 4'h0) & ~ctrl.irq_mask;
    wire         boundary   = (cpu.insn_done & ~cpu.insn_defers)
                            | cpu.insn_suspendable;
    wire         take_hw    = (state == S_IDLE) & req_ready & boundary
                            & (defer_cnt == 4'h0);
    wire         take_macro = take_hw & ctrl.service_mode_bit & (ctrl.mode != MODE_OFF);
    wire         take_vec   = take_hw & ~take_macro;
    wire         take_sw    = (state == S_IDLE) & ~take_hw & sw_pend;

    // channel data paths
    wire [15:0]  tdata      = ram[timer_data_pointer[7:0]];
    wire [15:0]  ddata      = ram[pattern_data_pointer[7:0]];
    wire [15:0]  next_cmp   = ctrl.auto_add ? compare_match_reg + tdata : tdata;
    wire [23:0]  step_ptr   = ctrl.step_up ? pattern_data_pointer + 24'h1
                                           : pattern_data_pointer - 24'h1;
    wire [7:0]   next_rc    = ring_step_counter - 8'h1;
    wire         ring_wrap  = ctrl.ring & (next_rc == 8'h0);
    wire [23:0]  next_dptr  = !ring_wrap ? step_ptr :
                              ctrl.step_up ? step_ptr - {16'h0, ring_length}
                                           : step_ptr + {16'h0, ring_length};
    wire [23:0]  next_tptr  = ctrl.retain_tptr ? timer_data_pointer :
                              ctrl.step_up ? timer_data_pointer + 24'h1
                                           : timer_data_pointer - 24'h1;
    wire         cnt_mode   = (ctrl.mode == MODE_COUNTER);
    wire [15:0]  cnt_now    = cnt_mode ? ram[chan_ptr] : transfer_count;
    wire [15:0]  cnt_dec    = cnt_now - `ONE16;
    wire         cnt_zero   = (cnt_dec == `ZERO16);
    wire         cnt_step   = (state == S_COUNT);
    assign flag_clr  = take_vec
                     | (cnt_step & ~(cnt_zero & ctrl.vector_on_complete_enable));
    assign next_flag = req_edge | (req_flag & ~flag_clr);

    // acknowledge time
    wire [11:0]  vec_w      = {4'h0, ack_cfg.vec_wait};
    wire [11:0]  stk_w      = {4'h0, ack_cfg.stack_wait};
    wire [11:0]  stk_extra  = ack_cfg.stack_slow ? `SLOW_STK_CLKS + (stk_w << 2) :
                              ack_cfg.stack_peripheral_ram ? `PERIPHERAL_RAM_STK_CLKS : 12'h000;
    wire [11:0]  odd_extra  = (ack_cfg.stack_peripheral_ram & ack_cfg.sp_odd) ? `ODD_SP_CLKS
                                                                    : 12'h000;
    wire         ctx        = ack_cfg.ctx_switch & ~take_sw;
    wire [11:0]  ack_total  = (ctx ? `ACK_CS_CLKS + vec_w
                                   : `ACK_VEC_CLKS + (vec_w << 1) + stk_extra)
                            + odd_extra + {4'h0, ack_cfg.branch_wait};

    // pin synchroniser and request flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_s1   <= 1'b0;
            req_s2   <= 1'b0;
            req_s3   <= 1'b0;
            req_flag <= 1'b0;
        end else begin
            req_s1   <= external_edge_request;
            req_s2   <= req_s1;
            req_s3   <= req_s2;
            req_flag <= next_flag;
        end
    end

    // priority and defer timers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_cnt  <= 4'h0;
            defer_cnt <= 4'h0;
            sw_pend   <= 1'b0;
        end else begin
            if (req_edge)
                prio_cnt <= `PRIO_CLKS;
            else if (prio_cnt != 4'h0)
                prio_cnt <= prio_cnt - 4'h1;
            if (cpu.insn_done & cpu.insn_defers)
                defer_cnt <= `DEFER_CLKS;
            else if (defer_cnt != 4'h0)
                defer_cnt <= defer_cnt - 4'h1;
            sw_pend <= cpu.sw_irq | (sw_pend & ~take_sw);
        end
    end

    // sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state         <= S_IDLE;
            suspended     <= 1'b0;
            suspend_req   <= 1'b0;
            resume_pulse  <= 1'b0;
            handler_start <= 1'b0;
            handler_ctx   <= 1'b0;
            ack_cnt       <= 12'h000;
            channel_busy  <= 1'b0;
        end else begin
            resume_pulse  <= 1'b0;
            handler_start <= 1'b0;
            unique case (state)
                S_IDLE: begin
                    if (take_hw | take_sw) begin
                        suspended    <= cpu.insn_suspendable & ~take_sw;
                        suspend_req  <= cpu.insn_suspendable & ~take_sw;
                        channel_busy <= 1'b1;
                    end
                    if (take_macro) begin
                        state <= (ctrl.mode == MODE_PATTERN) ? S_TIMER : S_COUNT;
                    end else if (take_vec | take_sw) begin
                        ack_cnt     <= ack_total;
                        handler_ctx <= ctx;
                        state       <= S_ACK;
                    end
                end
                S_TIMER: state <= S_DATA;
                S_DATA:  state <= S_COUNT;
                S_COUNT: begin
                    state        <= S_IDLE;
                    channel_busy <= 1'b0;
                    resume_pulse <= suspended;
                    suspend_req  <= 1'b0;
                    suspended    <= 1'b0;
                end
                S_ACK: begin
                    if (ack_cnt <= 12'h001) begin
                        handler_start <= 1'b1;
                        channel_busy  <= 1'b0;
                        suspend_req   <= 1'b0;
                        suspended     <= 1'b0;
                        state         <= S_IDLE;
                    end else begin
                        ack_cnt <= ack_cnt - 12'h001;
                    end
                end
            endcase
        end
    end

    // channel registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl                  <= ctrl_s'(`CTRL_RST);
            ack_cfg               <= '0;
            transfer_count        <= `ZERO16;
            chan_ptr              <= 8'h00;
            timer_data_pointer    <= 24'h0;
            pattern_data_pointer  <= 24'h0;
            ring_length           <= 8'h00;
            ring_step_counter     <= 8'h00;
            compare_match_reg     <= `ZERO16;
            pattern_output_buffer <= 8'h00;
        end else begin
            if (wr_ctrl) ctrl <= ctrl_s'(pwdata[8:0]);
            if (apb_wr & hit(paddr, `OFF_ACKCFG)) ack_cfg <= ack_cfg_s'(pwdata[27:0]);
            if (apb_wr & hit(paddr, `OFF_CHAN)) chan_ptr <= pwdata[7:0];
            if (wr_count) transfer_count <= pwdata[15:0];
            if (wr_tptr) timer_data_pointer <= pwdata[23:0];
            if (wr_dptr) pattern_data_pointer <= pwdata[23:0];
            if (wr_cmp) compare_match_reg <= pwdata[15:0];
            if (wr_ring) begin
                ring_length       <= pwdata[7:0];
                ring_step_counter <= pwdata[15:8];
            end
            if (state == S_TIMER) begin
                compare_match_reg  <= next_cmp;
                timer_data_pointer <= next_tptr;
            end
            if (state == S_DATA) begin
                pattern_output_buffer <= ddata[7:0];
                pattern_data_pointer  <= next_dptr;
                if (ctrl.ring)
                    ring_step_counter <= ring_wrap ? ring_length : next_rc;
            end
            if (cnt_step) begin
                if (!cnt_mode) transfer_count <= cnt_dec;
                if (cnt_zero) ctrl.service_mode_bit <= 1'b0;
            end
        end
    end

    // channel memory
    always_ff @(posedge pclk) begin
        if (cnt_step & cnt_mode)
            ram[chan_ptr] <= cnt_dec;
        else if (apb_wr & ram_sel)
            ram[ram_idx] <= pwdata[15:0];
    end

    // apb answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= apb_acc;
            pslverr <= apb_acc & ~mapped;
            prdata  <= (apb_acc & ~pwrite) ? rd_val : 32'h0;
        end
    end
endmodule : interrupt_macro_service_sequencer

// ===== verif/imss_checker.sv
// Purpose: port-level assertions for the service sequencer
// Assumes: one clock pclk, presetn asynchronous active low
// Notes:   bound into the design below the module
`timescale 1ns/1ps
module imss_checker (
    // clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // apb
    input wire logic              psel,
    input wire logic              penable,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // requests and cpu
    input wire logic              external_edge_request,
    input wire imss_pkg::cpu_in_s cpu,
    input wire logic              suspend_req,
    input wire logic              resume_pulse,
    input wire logic              handler_start,
    input wire logic              channel_busy,
    // targets
    input wire logic [15:0]       compare_match_reg,
    input wire logic [7:0]        pattern_output_buffer
);
    import imss_pkg::*;
    logic [7:0] since;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // cycles since the current take
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) since <= 8'h00;
        else if (!channel_busy) since <= 8'h00;
        else if (since != 8'hFF) since <= since + 8'h01;
    end
    sequence s_defer;
        cpu.insn_done && cpu.insn_defers && !cpu.sw_irq && !channel_busy && !suspend_req;
    endsequence
    sequence s_idle_edge;
        $rose(external_edge_request) && !channel_busy && !suspend_req;
    endsequence
    property p_apb_wait; psel && penable && !pready |=> pready; endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("pready late");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero");
    property p_defer; s_defer |=> (!channel_busy && !suspend_req) [*8]; endproperty
    a_defer: assert property (p_defer) else $error("take inside hold");
    property p_prio; s_idle_edge |=> !channel_busy [*8]; endproperty
    a_prio: assert property (p_prio) else $error("take before priority");
    property p_ack_min; handler_start |-> since >= 8'd22; endproperty
    a_ack_min: assert property (p_ack_min) else $error("handler too early");
    property p_hs_pulse; handler_start |=> !handler_start; endproperty
    a_hs_pulse: assert property (p_hs_pulse) else $error("handler_start too long");
    property p_take_end;
        $rose(suspend_req) |-> $past(cpu.insn_done || cpu.insn_suspendable || cpu.sw_irq);
    endproperty
    a_take_end: assert property (p_take_end) else $error("take mid instruction");
    property p_hold;
        !channel_busy && !psel |=> $stable(compare_match_reg) && $stable(pattern_output_buffer);
    endproperty
    a_hold: assert property (p_hold) else $error("target moved while idle");
    property p_resume; resume_pulse |-> $past(suspend_req) ##1 !resume_pulse; endproperty
    a_resume: assert property (p_resume) else $error("resume unexpected");
endmodule : imss_checker
bind interrupt_macro_service_sequencer imss_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_edge_request(external_edge_request),
    .cpu(cpu), .suspend_req(suspend_req), .resume_pulse(resume_pulse),
    .handler_start(handler_start), .channel_busy(channel_busy),
    .compare_match_reg(compare_match_reg), .pattern_output_buffer(pattern_output_buffer));

// ===== verif/cpu_model.sv
// Purpose: cpu sequencer and edge source model
// Assumes: an instruction ends every ilen+1 clocks unless a block op runs
// Notes:   deferring and software requests come on bench command
`timescale 1ns/1ps
module cpu_model (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // bench commands
    input  wire logic         defer_req,
    input  wire logic         sw_req,
    input  wire logic         edge_req,
    input  wire logic         blk,
    input  wire logic [3:0]   ilen,
    // toward the design
    output imss_pkg::cpu_in_s cpu,
    output logic              edge_pin
);
    import imss_pkg::*;
    logic [3:0] tick;
    logic [2:0] hold;
    wire        ends = (tick >= ilen) && !blk;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 4'h0;
            hold <= 3'h0;
            cpu <= '0;
            edge_pin <= 1'b0;
        end else begin
            tick <= ends ? 4'h0 : tick + 4'h1;
            cpu.insn_done <= ends || defer_req;
            cpu.insn_defers <= defer_req;
            cpu.insn_suspendable <= blk;
            cpu.sw_irq <= sw_req;
            hold <= edge_req ? 3'h4 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
            edge_pin <= edge_req || hold > 3'h1;
        end
    end
endmodule : cpu_model

// ===== verif/tb.sv
// Purpose: self-checking bench for the service sequencer
// Assumes: pclk 200 MHz, one APB transfer per task call
// Notes:   reads queue their expected value, a monitor compares
`timescale 1ns/1ps
`include "imss_consts.svh"
module tb;
    import imss_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, edge_pin;
    logic        suspend_req, resume_pulse, handler_start, handler_ctx, channel_busy;
    logic        defer_req, sw_req, edge_req, blk;
    logic [3:0]  ilen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [15:0] compare_match_reg, cmp, dt;
    logic [7:0]  pattern_output_buffer;
    cpu_in_s     cpu;
    logic [32:0] expq [$];
    int          bad_count, tests_run, seed, n, i;
    interrupt_macro_service_sequencer uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_edge_request(edge_pin), .cpu(cpu), .suspend_req(suspend_req),
        .resume_pulse(resume_pulse), .handler_start(handler_start), .handler_ctx(handler_ctx),
        .channel_busy(channel_busy), .compare_match_reg(compare_match_reg),
        .pattern_output_buffer(pattern_output_buffer));
    cpu_model partner (
        .pclk(pclk), .presetn(presetn), .defer_req(defer_req), .sw_req(sw_req),
        .edge_req(edge_req), .blk(blk), .ilen(ilen), .cpu(cpu), .edge_pin(edge_pin));
    task automatic check(input string nm, input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task automatic bound(input int k);
        if (k >= 300) begin
            bad_count++;
            end_sim();
        end
    endtask : bound
    task automatic wait_on(ref logic s, output int k);
        k = 0;
        while (s !== 1'b1 && k < 300) begin
            @(negedge pclk);
            k++;
        end
        bound(k);
        @(posedge pclk);
    endtask : wait_on
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 300);
        bound(k);
        @(posedge pclk);
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic fire;
        edge_req <= 1'b1;
        @(posedge pclk);
        edge_req <= 1'b0;
    endtask : fire
    // vectored or context take with a deferring instruction ahead of it
    task automatic ack(input logic [31:0] cfg, input int e);
        int k;
        wr(`OFF_ACKCFG, cfg);
        fire();
        repeat (6) @(posedge pclk);
        defer_req <= 1'b1;
        @(posedge pclk);
        defer_req <= 1'b0;
        wait_on(channel_busy, k);
        wait_on(handler_start, k);
        check("ack_time", k, e);
        check("ack_kind", handler_ctx, cfg[0]);
        repeat (4) @(posedge pclk);
    endtask : ack
    always @(negedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
            check("read", {pslverr, prdata}, expq.pop_front());
    end
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        #100000;
        bad_count++;
        end_sim();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {defer_req, sw_req, edge_req, blk} = 4'h0;
        ilen = 4'h2;
        seed = 33;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`OFF_CTRL, {24'h0, `CTRL_RST});
        rd(12'h300, {1'b1, 32'h0});
        wr(`OFF_CTRL, 32'h0);
        ack(32'h1, 22);
        ack(32'h20, 30);
        ack(32'h21, 24);
        ack(32'h6, 33);
        ack(32'h5000, 31);
        ack(32'h200008, 45);
        ack(32'h0, 26);
        {defer_req, sw_req} <= 2'b11;
        @(posedge pclk);
        {defer_req, sw_req} <= 2'b00;
        wait_on(handler_start, n);
        check("sw_latency", n <= 30, 1'b1);
        {cmp, dt} = $random(seed);
        rv = $random(seed);
        wr(`OFF_RAM + 12'h040, {16'h0, dt});
        wr(`OFF_RAM + 12'h080, {24'h0, rv[7:0]});
        wr(`OFF_RAM + 12'h084, {24'h0, rv[15:8]});
        wr(`OFF_COUNT, 32'h3);
        wr(`OFF_TPTR, 32'h10);
        wr(`OFF_DPTR, 32'h20);
        wr(`OFF_RING, 32'h0202);
        wr(`OFF_CMP, {16'h0, cmp});
        wr(`OFF_CTRL, 32'hFD);
        blk <= 1'b1;
        for (i = 0; i < 3; i++) begin
            fire();
            wait_on(resume_pulse, n);
            cmp = cmp + dt;
            check("compare", compare_match_reg, cmp);
            check("pattern", pattern_output_buffer, i == 1 ? rv[15:8] : rv[7:0]);
            rd(`OFF_COUNT, 33'(2 - i));
        end
        wait_on(handler_start, n);
        check("zero_irq", n < 60, 1'b1);
        rd(`OFF_CTRL, 33'hED);
        blk <= 1'b0;
        wr(`OFF_RAM + 12'h0C0, 32'h2);
        wr(`OFF_CHAN, 32'h30);
        wr(`OFF_CTRL, 32'h12);
        for (i = 0; i < 2; i++) begin
            fire();
            wait_on(channel_busy, n);
            rd(`OFF_RAM + 12'h0C0, 33'(1 - i));
        end
        check("cmp_kept", compare_match_reg, cmp);
        rd(`OFF_CTRL, 33'h2);
        rd(`OFF_STAT, 33'h0);
        end_sim();
    end
endmodule : tb
